// File: logic/fault_log_pkg.sv
/*
  Constants, layouts and arithmetic helpers for the fault history log.
  Assumes one 125 MHz clock and APB access with 12-bit byte addresses.
*/
package fault_log_pkg;

  localparam int unsigned LOG_DEPTH = 10;
  localparam int unsigned ADDR_W = 12;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PUP_CLOCK = 12'h004;
  localparam logic [11:0] ADDR_YEARS_DAYS = 12'h008;
  localparam logic [11:0] ADDR_CODE_BASE = 12'h040;
  localparam logic [11:0] ADDR_SLOT_BASE = 12'h080;
  localparam logic [11:0] ADDR_GROUP_MASK = 12'hFC0;

  // Control register fields and reset value
  localparam int unsigned CTRL_CONTENT_BIT = 0;
  localparam int unsigned CTRL_SOURCE_BIT = 1;
  localparam int unsigned CTRL_PARALLEL_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Fault codes raised by power module hardware
  localparam logic [7:0] FAULT_PM_FIRST = 8'h65;
  localparam logic [7:0] FAULT_PM_LAST = 8'h6E;
  localparam logic [7:0] FAULT_HW_THIRTY = 8'h1E;
  localparam logic [7:0] FAULT_HW_THIRTY_ONE = 8'h1F;

  // Time arithmetic
  localparam logic [31:0] MIN_PER_HOUR = 32'h0000_003C;
  localparam logic [31:0] HOURS_SCALE = 32'h0000_0064;
  localparam logic [31:0] MIN_PER_DAY = 32'h0000_05A0;
  localparam logic [31:0] DAYS_PER_YEAR = 32'h0000_016D;
  localparam logic [31:0] YEAR_SCALE = 32'h0000_03E8;
  localparam logic [31:0] SAT_HOURS = 32'h0000_0258;
  localparam logic [31:0] SAT_MINUTES = SAT_HOURS * MIN_PER_HOUR;
  localparam logic [15:0] SAT_SLOT = 16'hEA60;

  typedef enum logic [0:0] {
    APB_IDLE = 1'b0,
    APB_DONE = 1'b1
  } apb_state_e;

  typedef struct packed {
    logic [7:0] code;
    logic [31:0] stamp;
    logic [15:0] slot;
  } log_entry_s;

  // Minutes to hours*100 + minutes
  function automatic logic [15:0] hm_encode(input logic [31:0] m);
    logic [31:0] h;
    h = m / MIN_PER_HOUR;
    return 16'(h * HOURS_SCALE + (m % MIN_PER_HOUR));
  endfunction

  function automatic logic is_pm_fault(input logic [7:0] c);
    return (c >= FAULT_PM_FIRST && c <= FAULT_PM_LAST) ||
           c == FAULT_HW_THIRTY || c == FAULT_HW_THIRTY_ONE;
  endfunction

  // Difference newest - older, floored at zero and capped at 600 hours
  function automatic logic [15:0] diff_slot(input logic [31:0] newest, input logic [31:0] older);
    logic [31:0] d;
    d = (older > newest) ? 32'h0000_0000 : newest - older;
    if (d > SAT_MINUTES) d = SAT_MINUTES;
    return hm_encode(d);
  endfunction

endpackage

// File: logic/time_stamp_encode.sv
/*
  Splits an absolute time in minutes into years.days and hours.minutes
  display values. Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
module time_stamp_encode
  import fault_log_pkg::*;
(
  input wire logic [31:0] abs_min,
  output logic [15:0] years_days,
  output logic [15:0] hours_minutes
);
  logic [31:0] days;

  always_comb begin
    days = abs_min / MIN_PER_DAY;
    years_days = 16'((days / DAYS_PER_YEAR) * YEAR_SCALE + (days % DAYS_PER_YEAR));
    hours_minutes = hm_encode(abs_min % MIN_PER_DAY);
  end
endmodule // time_stamp_encode

// File: logic/fault_log_timestamp.sv
/*
  Ten-entry fault history with per-entry module number or fault time,
  reached over APB. Assumes fault, tick and power events are one-cycle
  pulses synchronous to mclk, and run_time_min counts minutes.
*/
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module fault_log_timestamp
  import fault_log_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_valid,
  input wire logic [7:0] fault_code,
  input wire logic [15:0] fault_module,
  input wire logic minute_tick,
  input wire logic [31:0] run_time_min,
  input wire logic power_up,
  input wire logic power_down
);

  apb_state_e apb_state_q, apb_state_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  logic log_content_select_q, log_content_select_d;
  logic clock_source_select_q, clock_source_select_d;
  logic parallel_if_q, parallel_if_d;
  logic [31:0] pup_min_q, pup_min_d;

  log_entry_s log_q [LOG_DEPTH];
  log_entry_s log_d [LOG_DEPTH];
  log_entry_s saved_q [LOG_DEPTH];
  log_entry_s saved_d [LOG_DEPTH];
  logic [15:0] years_days_q, years_days_d;
  logic [15:0] saved_yd_q, saved_yd_d;

  logic wr_take;
  logic rd_start;
  logic src_change;
  logic [31:0] now_min;
  logic [15:0] now_yd;
  logic [15:0] now_hm;
  logic [3:0] rd_idx;

  assign now_min = clock_source_select_q ? run_time_min : pup_min_q;
  assign wr_take = psel && penable && pwrite && apb_state_q == APB_DONE;
  assign rd_start = psel && penable && apb_state_q == APB_IDLE;
  assign rd_idx = paddr[5:2];
  assign src_change = wr_take && paddr == ADDR_CTRL &&
                      pwdata[CTRL_SOURCE_BIT] != clock_source_select_q;

  time_stamp_encode u_encode (
    .abs_min(now_min),
    .years_days(now_yd),
    .hours_minutes(now_hm)
  );

  // APB slave: one wait cycle, so pready can come from a flop
  always_comb begin
    apb_state_d = apb_state_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    case (apb_state_q)
      APB_IDLE: begin
        if (rd_start) begin
          apb_state_d = APB_DONE;
          pready_d = 1'b1;
          prdata_d = 32'h0000_0000;
          if (paddr == ADDR_CTRL) begin
            prdata_d[CTRL_CONTENT_BIT] = log_content_select_q;
            prdata_d[CTRL_SOURCE_BIT] = clock_source_select_q;
            prdata_d[CTRL_PARALLEL_BIT] = parallel_if_q;
          end else if (paddr == ADDR_PUP_CLOCK) begin
            prdata_d = pup_min_q;
          end else if (paddr == ADDR_YEARS_DAYS) begin
            // Module mode pins the years.days slot to zero
            prdata_d[15:0] = log_content_select_q ? years_days_q : 16'h0000;
          end else if ((paddr & ADDR_GROUP_MASK) == ADDR_CODE_BASE && paddr[1:0] == 2'b00 &&
                       rd_idx < 4'(LOG_DEPTH)) begin
            prdata_d[7:0] = log_q[rd_idx].code;
          end else if ((paddr & ADDR_GROUP_MASK) == ADDR_SLOT_BASE && paddr[1:0] == 2'b00 &&
                       rd_idx < 4'(LOG_DEPTH)) begin
            // A plain single-module drive shows no module numbers at all
            if (log_content_select_q || parallel_if_q) begin
              prdata_d[15:0] = log_q[rd_idx].slot;
            end
          end else begin
            pslverr_d = 1'b1;
          end
          if (pwrite) begin
            prdata_d = 32'h0000_0000;
            pslverr_d = !(paddr == ADDR_CTRL || paddr == ADDR_PUP_CLOCK);
          end
        end
      end
      APB_DONE: begin
        apb_state_d = APB_IDLE;
        prdata_d = prdata_q;
      end
      default: apb_state_d = APB_IDLE;
    endcase
  end

  // Control registers and the powered-up clock
  always_comb begin
    log_content_select_d = log_content_select_q;
    clock_source_select_d = clock_source_select_q;
    parallel_if_d = parallel_if_q;
    pup_min_d = minute_tick ? pup_min_q + 32'h0000_0001 : pup_min_q;
    if (wr_take && paddr == ADDR_CTRL) begin
      log_content_select_d = pwdata[CTRL_CONTENT_BIT];
      clock_source_select_d = pwdata[CTRL_SOURCE_BIT];
      parallel_if_d = pwdata[CTRL_PARALLEL_BIT];
    end
    // Rewriting the clock touches no entry; captured stamps stay
    if (wr_take && paddr == ADDR_PUP_CLOCK) pup_min_d = pwdata;
  end

  // Log: clear, then power events, then the fault, so a fault never gets lost
  always_comb begin
    log_d = log_q;
    saved_d = saved_q;
    years_days_d = years_days_q;
    saved_yd_d = saved_yd_q;
    if (src_change) begin
      for (int i = 0; i < LOG_DEPTH; i++) begin
        log_d[i] = '0;
        saved_d[i] = '0;
      end
      years_days_d = 16'h0000;
      saved_yd_d = 16'h0000;
    end
    if (power_down && clock_source_select_q) begin
      saved_d = log_d;
      saved_yd_d = years_days_d;
    end
    if (power_up) begin
      for (int i = 0; i < LOG_DEPTH; i++) begin
        // Restore from the post-clear copy so a same-cycle source change still wins
        if (clock_source_select_q) begin
          log_d[i].stamp = saved_d[i].stamp;
          if (log_content_select_q) log_d[i].slot = saved_d[i].slot;
        end else begin
          log_d[i].stamp = 32'h0000_0000;
          if (log_content_select_q) log_d[i].slot = 16'h0000;
        end
      end
      years_days_d = clock_source_select_q ? saved_yd_d : 16'h0000;
    end
    if (fault_valid) begin
      for (int i = LOG_DEPTH - 1; i > 0; i--) begin
        log_d[i].code = log_d[i-1].code;
        log_d[i].stamp = log_d[i-1].stamp;
        if (log_content_select_q) begin
          // Older slots become differences to the new stamp
          log_d[i].slot = diff_slot(now_min, log_d[i-1].stamp);
        end else begin
          log_d[i].slot = log_d[i-1].slot;
        end
      end
      log_d[0].code = fault_code;
      log_d[0].stamp = now_min;
      if (log_content_select_q) begin
        log_d[0].slot = now_hm;
        years_days_d = now_yd;
      end else begin
        // Raw count in hundredths: module one reads 0.01
        log_d[0].slot = (parallel_if_q && is_pm_fault(fault_code)) ? fault_module : 16'h0000;
        years_days_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      apb_state_q <= APB_IDLE;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      log_content_select_q <= CTRL_RESET[CTRL_CONTENT_BIT];
      clock_source_select_q <= CTRL_RESET[CTRL_SOURCE_BIT];
      parallel_if_q <= CTRL_RESET[CTRL_PARALLEL_BIT];
      pup_min_q <= 32'h0000_0000;
      years_days_q <= 16'h0000;
      saved_yd_q <= 16'h0000;
      for (int i = 0; i < LOG_DEPTH; i++) begin
        log_q[i] <= '0;
        saved_q[i] <= '0;
      end
    end else begin
      apb_state_q <= apb_state_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      log_content_select_q <= log_content_select_d;
      clock_source_select_q <= clock_source_select_d;
      parallel_if_q <= parallel_if_d;
      pup_min_q <= pup_min_d;
      years_days_q <= years_days_d;
      saved_yd_q <= saved_yd_d;
      log_q <= log_d;
      saved_q <= saved_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  AST_PM_MODULE: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && !log_content_select_q && parallel_if_q && is_pm_fault(fault_code))
    |=> log_q[0].slot == $past(fault_module))
    else $error("module number not recorded for power module fault");

  AST_MODULE_SHIFT: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && !log_content_select_q && !src_change && !power_up)
    |=> log_q[1].slot == $past(log_q[0].slot) && log_q[9].code == $past(log_q[8].code))
    else $error("module slots did not follow the code log");

  AST_SINGLE_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_start && !pwrite && (paddr & ADDR_GROUP_MASK) == ADDR_SLOT_BASE &&
     !log_content_select_q && !parallel_if_q)
    |=> pready_q && prdata_q == 32'h0000_0000)
    else $error("single module drive showed a module number");

  AST_YD_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_start && !pwrite && paddr == ADDR_YEARS_DAYS && !log_content_select_q)
    |=> prdata_q == 32'h0000_0000)
    else $error("years.days not zero in module mode");

  AST_NEWEST_STAMP: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q && !clock_source_select_q)
    |=> log_q[0].stamp == $past(pup_min_q) && log_q[0].code == $past(fault_code))
    else $error("newest stamp not taken from powered-up clock");

  AST_SATURATE: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q) |=> log_q[1].slot <= SAT_SLOT)
    else $error("time difference above 600.00");

  AST_NEG_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q && !src_change && !power_up &&
     log_q[0].stamp > now_min) |=> log_q[1].slot == 16'h0000)
    else $error("negative difference not stored as zero");

  AST_SOURCE_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    (src_change && !fault_valid) |=> log_q[0].code == 8'h00 && log_q[9].slot == 16'h0000)
    else $error("clock source change did not clear the logs");

  AST_PUP_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    (power_up && !clock_source_select_q && log_content_select_q && !fault_valid)
    |=> log_q[3].slot == 16'h0000 && years_days_q == 16'h0000)
    else $error("power-up did not clear time entries");

  AST_RESTORE: assert property (@(posedge mclk) disable iff (!rstn)
    (power_up && clock_source_select_q && !fault_valid && !src_change)
    |=> log_q[2].stamp == $past(saved_q[2].stamp))
    else $error("run-time stamps not restored at power-up");

  AST_OTHER_FAULT_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && !log_content_select_q && !is_pm_fault(fault_code))
    |=> log_q[0].slot == 16'h0000)
    else $error("module number recorded for a fault outside the power module set");

  AST_NEWEST_RUNTIME: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q && clock_source_select_q)
    |=> log_q[0].stamp == $past(run_time_min) && log_q[0].code == $past(fault_code))
    else $error("newest stamp not taken from run-time clock");

  AST_TIME_SHIFT: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q && !src_change && !power_up)
    |=> log_q[9].stamp == $past(log_q[8].stamp) && log_q[1].code == $past(log_q[0].code))
    else $error("time entries did not shift with the code log");

  AST_OLDER_DIFF: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q && !src_change && !power_up &&
     log_q[0].stamp <= now_min && now_min - log_q[0].stamp <= SAT_MINUTES)
    |=> (log_q[1].slot / HOURS_SCALE) * MIN_PER_HOUR + log_q[1].slot % HOURS_SCALE ==
        $past(now_min) - $past(log_q[0].stamp))
    else $error("older entry does not hold the difference to the newest fault");

  AST_SAT_EXACT: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q && !src_change && !power_up &&
     now_min > log_q[0].stamp + SAT_MINUTES)
    |=> log_q[1].slot == SAT_SLOT)
    else $error("long difference not stored as 600.00");

  AST_PUP_KEEP: assert property (@(posedge mclk) disable iff (!rstn)
    (wr_take && paddr == ADDR_PUP_CLOCK && !fault_valid && !power_up)
    |=> log_q[1].slot == $past(log_q[1].slot) && log_q[0].stamp == $past(log_q[0].stamp))
    else $error("clock rewrite disturbed the time log");

  AST_HM_MINUTES: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && log_content_select_q)
    |=> (log_q[0].slot % HOURS_SCALE) < MIN_PER_HOUR)
    else $error("minutes part of newest time above 59");

  AST_YD_MODULE: assert property (@(posedge mclk) disable iff (!rstn)
    (fault_valid && !log_content_select_q)
    |=> years_days_q == 16'h0000)
    else $error("years.days stored in module mode");

  AST_SAVE: assert property (@(posedge mclk) disable iff (!rstn)
    (power_down && clock_source_select_q && !src_change)
    |=> saved_q[4].stamp == $past(log_q[4].stamp) && saved_q[0].slot == $past(log_q[0].slot))
    else $error("run-time stamps not saved at power-down");

endmodule // fault_log_timestamp

// File: sim/tb.sv
/*
  Self-checking bench for the fault history log: APB register access,
  module-number mode, time mode with both clock sources and power events.
  Assumes the design answers every APB transfer by itself and that the
  fault, tick and power inputs are one-cycle pulses on mclk.
*/
`timescale 1ns/1ps
module tb
  import fault_log_pkg::*;
;
  typedef struct packed {
    logic [7:0] code;
    logic [15:0] module_num;
    logic [31:0] slot;
  } row_s;
  localparam logic [31:0] T_A = 32'h0000_0064;
  localparam logic [31:0] T_B = 32'h0000_8D40;
  localparam logic [31:0] T_C = 32'h0000_0096;
  localparam logic [31:0] T_D = T_C + 32'h0000_0046;
  localparam logic [31:0] T_R = 32'h0000_07D0;
  localparam logic [31:0] T_S = T_R + 32'h0000_012C;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
  logic fault_valid, minute_tick, power_up, power_down, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, run_time_min, rd;
  logic [7:0] fault_code;
  logic [15:0] fault_module;
  int errors, num_checks, cycles;
  row_s rows [7];

  fault_log_timestamp dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_valid(fault_valid), .fault_code(fault_code),
    .fault_module(fault_module), .minute_tick(minute_tick), .run_time_min(run_time_min),
    .power_up(power_up), .power_down(power_down));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Backstop on run length; apb itself gives up waiting for pready after 50 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // Starts on a fresh edge so release and the next setup never share a time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // Sampled at the rising edge; release happens at that same edge
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    cmp_bit(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cmp_bit(er, 1'b0);
  endtask

  task automatic chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp_bit(er, 1'b0);
    cmp_data(rd, exp);
  endtask

  task automatic fault(input logic [7:0] c, input logic [15:0] m);
    @(posedge mclk);
    fault_valid <= 1'b1;
    fault_code <= c;
    fault_module <= m;
    @(posedge mclk);
    fault_valid <= 1'b0;
  endtask

  function automatic logic [11:0] sa(input int i);
    return ADDR_SLOT_BASE + 12'(4 * i);
  endfunction

  function automatic logic [11:0] ca(input int i);
    return ADDR_CODE_BASE + 12'(4 * i);
  endfunction

  function automatic logic [31:0] hm(input logic [31:0] m);
    return (m / MIN_PER_HOUR) * HOURS_SCALE + m % MIN_PER_HOUR;
  endfunction

  function automatic logic [31:0] dif(input logic [31:0] n, input logic [31:0] o);
    if (o > n) return 32'h0000_0000;
    return (n - o > SAT_MINUTES) ? hm(SAT_MINUTES) : hm(n - o);
  endfunction

  initial begin
    {rstn, psel, penable, pwrite, fault_valid, minute_tick, power_up, power_down} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    run_time_min = 32'h0000_0000;
    fault_code = 8'h00;
    fault_module = 16'h0000;
    errors = 0;
    num_checks = 0;
    // Codes 100 and 111 sit just outside the power-module range
    rows[0] = '{8'h65, 16'h0001, 32'h0000_0001};
    rows[1] = '{8'h6E, 16'h0003, 32'h0000_0003};
    rows[2] = '{8'h1E, 16'h0002, 32'h0000_0002};
    rows[3] = '{8'h1F, 16'h0004, 32'h0000_0004};
    rows[4] = '{8'h32, 16'h0005, 32'h0000_0000};
    rows[5] = '{8'h64, 16'h0006, 32'h0000_0000};
    rows[6] = '{8'h6F, 16'h0007, 32'h0000_0000};
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    chk(ADDR_CTRL, 32'h0000_0000);
    chk(ADDR_PUP_CLOCK, 32'h0000_0000);
    chk(sa(0), 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    cmp_bit(er, 1'b1);
    cmp_data(rd, 32'h0000_0000);
    apb(1'b1, ADDR_YEARS_DAYS, 32'h0000_0005);
    cmp_bit(er, 1'b1);
    chk(ADDR_YEARS_DAYS, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0004);
    foreach (rows[i]) begin
      fault(rows[i].code, rows[i].module_num);
      chk(ca(0), {24'h00_0000, rows[i].code});
      chk(sa(0), rows[i].slot);
      chk(ADDR_YEARS_DAYS, 32'h0000_0000);
      if (i > 0) chk(sa(1), rows[i - 1].slot);
    end
    wr(ADDR_CTRL, 32'h0000_0000);
    fault(8'h65, 16'h0001);
    for (int i = 0; i < 10; i++) chk(sa(i), 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_PUP_CLOCK, T_A);
    fault(8'h0A, 16'h0000);
    chk(ca(0), 32'h0000_000A);
    chk(sa(0), hm(T_A));
    wr(ADDR_PUP_CLOCK, T_B);
    fault(8'h0B, 16'h0000);
    chk(sa(0), hm(T_B % MIN_PER_DAY));
    chk(ADDR_YEARS_DAYS, 32'h0000_0019);
    chk(sa(1), dif(T_B, T_A));
    wr(ADDR_PUP_CLOCK, T_C);
    chk(sa(1), dif(T_B, T_A));
    fault(8'h0C, 16'h0000);
    chk(sa(1), 32'h0000_0000);
    chk(sa(2), dif(T_C, T_A));
    repeat (70) begin
      @(posedge mclk);
      minute_tick <= 1'b1;
      @(posedge mclk);
      minute_tick <= 1'b0;
    end
    fault(8'h0D, 16'h0000);
    chk(sa(0), hm(T_D));
    chk(sa(1), dif(T_D, T_C));
    chk(sa(3), dif(T_D, T_A));
    chk(ca(3), 32'h0000_000A);
    @(posedge mclk);
    power_up <= 1'b1;
    @(posedge mclk);
    power_up <= 1'b0;
    for (int i = 0; i < 4; i++) chk(sa(i), 32'h0000_0000);
    chk(ADDR_YEARS_DAYS, 32'h0000_0000);
    chk(ca(0), 32'h0000_000D);
    wr(ADDR_CTRL, 32'h0000_0003);
    for (int i = 0; i < 10; i++) begin
      chk(ca(i), 32'h0000_0000);
      chk(sa(i), 32'h0000_0000);
    end
    @(posedge mclk);
    run_time_min <= T_R;
    fault(8'h0E, 16'h0000);
    chk(sa(0), hm(T_R % MIN_PER_DAY));
    chk(ADDR_YEARS_DAYS, 32'h0000_0001);
    @(posedge mclk);
    run_time_min <= T_S;
    fault(8'h0F, 16'h0000);
    @(posedge mclk);
    power_down <= 1'b1;
    run_time_min <= 32'h0000_0003;
    @(posedge mclk);
    power_down <= 1'b0;
    @(posedge mclk);
    power_up <= 1'b1;
    @(posedge mclk);
    power_up <= 1'b0;
    chk(sa(0), hm(T_S % MIN_PER_DAY));
    chk(sa(1), dif(T_S, T_R));
    chk(ca(1), 32'h0000_000E);
    chk(ADDR_YEARS_DAYS, 32'h0000_0001);
    summarize();
  end
endmodule // tb
